// >>> tdac_map.svh
// Offsets, field positions, codes and reset values of the test DAC block.
// Included by the package user files; holds definitions only.
`ifndef TDAC_MAP_SVH
`define TDAC_MAP_SVH

// Register port offsets
`define TDAC_ADDR_W 2
`define TDAC_A_WORD 2'h0
`define TDAC_A_STATUS 2'h1
`define TDAC_A_TEST 2'h2
`define TDAC_A_OG 2'h3

// Control bits of a serial word select the target register
`define TDAC_CTRL_HI 3
`define TDAC_CTRL_LO 0
`define TDAC_SEL_TEST 4'hC
`define TDAC_SEL_OG 4'hD

// Test register: digital test mode field
`define TDAC_MODE_HI 17
`define TDAC_MODE_LO 14
`define TDAC_MODE_RAW 4'h7
`define TDAC_MODE_OFS 4'hA

// Offset and gain register fields
`define TDAC_GAIN_HI 30
`define TDAC_GAIN_LO 27
`define TDAC_OFS_HI 26
`define TDAC_OFS_LO 16
`define TDAC_PE_HI 15
`define TDAC_PE_LO 12

// Offset divisor 4096 as a shift
`define TDAC_OFS_FRAC 12

// Reset values
`define TDAC_TEST_RST 32'h0000000C
`define TDAC_OG_RST 32'h0000000D

`endif

// >>> tdac_pkg.sv
// Types shared by the test DAC block.
// No assumptions on the surroundings.
package tdac_pkg;
   typedef enum logic [1:0] {
      TDAC_OFF = 2'b00,
      TDAC_RAW = 2'b01,
      TDAC_OFS = 2'b10
   } tdac_mode_e;
endpackage

// >>> tdac_sdm.sv
// Second-order error-feedback sigma-delta modulator.
// Steps once per step pulse; cleared while not enabled.
`timescale 1ns/1ns
module tdac_sdm #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic step,
   input wire logic enable,
   // Data
   input wire logic signed [W-1:0] din,
   output logic bit_out
);
   localparam int EW = W + 4;

   logic signed [EW-1:0] e1;
   logic signed [EW-1:0] e2;
   logic signed [EW-1:0] next_e1;
   logic signed [EW-1:0] next_e2;
   logic next_bit;
   logic signed [EW-1:0] v;
   logic signed [EW-1:0] fs;

   always_comb begin
      next_e1 = e1;
      next_e2 = e2;
      next_bit = bit_out;
      fs = EW'(signed'({1'b0, {(W-1){1'b1}}}));
      // Noise shaped by (1 - z^-1)^2
      v = EW'(din) + (e1 <<< 1) - e2;
      if (!enable) begin
         next_e1 = '0;
         next_e2 = '0;
         next_bit = 1'b0;
      end else if (step) begin
         next_bit = ~v[EW-1];
         next_e2 = e1;
         next_e1 = v[EW-1] ? (v + fs) : (v - fs);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         e1 <= '0;
         e2 <= '0;
         bit_out <= 1'b0;
      end else begin
         e1 <= next_e1;
         e2 <= next_e2;
         bit_out <= next_bit;
      end
   end
endmodule

// >>> tdac_stretch.sv
// Holds each output bit for code+1 steps.
// Step pulses come from the recovery clock edge detector.
`timescale 1ns/1ns
module tdac_stretch #(
   parameter int CW = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic step,
   input wire logic [CW-1:0] code,
   // Data
   input wire logic din,
   output logic dout
);
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic next_dout;
   logic take;

   always_comb begin
      next_cnt = cnt;
      next_dout = dout;
      take = 1'b0;
      if (step) begin
         if (cnt != '0) begin
            next_cnt = cnt - CW'(1);
         end else begin
            take = 1'b1;
            next_dout = din;
            next_cnt = code;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt <= '0;
         dout <= 1'b0;
      end else begin
         cnt <= next_cnt;
         dout <= next_dout;
      end
   end
endmodule

// >>> tdac_top.sv
// Test DAC control: serial register words, offset and gain, modulator.
// Assumes filter outputs and demodulator select come from CORE_CLK logic;
// the recovery clock arrives as a pin and is sampled here.
`timescale 1ns/1ns
`include "tdac_map.svh"
module tdac_top #(
   parameter int DW = 16
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_B,
   // Register port
   input wire logic [`TDAC_ADDR_W-1:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // Demodulator side
   input wire logic LIN_ACTIVE,
   input wire logic [DW-1:0] CORR_FILT,
   input wire logic [DW-1:0] LIN_FILT,
   // Recovery clock pin
   input wire logic RECOVERY_CLOCK,
   // Outputs
   output logic CLOCK_OUTPUT_PIN,
   output logic DAC_ENABLED
);
   localparam int GW = `TDAC_GAIN_HI - `TDAC_GAIN_LO + 1;
   localparam int OW = `TDAC_OFS_HI - `TDAC_OFS_LO + 1;
   localparam int PW = `TDAC_PE_HI - `TDAC_PE_LO + 1;
   localparam int XW = DW + `TDAC_OFS_FRAC + 1;
   localparam int SW = XW + (1 << GW);

   // Register select from the low control bits of a word
   function automatic logic sel_is(input logic [31:0] w, input logic [3:0] code);
      sel_is = (w[`TDAC_CTRL_HI:`TDAC_CTRL_LO] == code);
   endfunction

   // Clamp a wide signed value into the DAC input range
   function automatic logic signed [DW-1:0] sat(input logic signed [SW-1:0] v);
      logic signed [SW-1:0] hi;
      logic signed [SW-1:0] lo;
      hi = SW'(signed'({1'b0, {(DW-1){1'b1}}}));
      lo = ~hi;
      if (v > hi) begin
         sat = hi[DW-1:0];
      end else if (v < lo) begin
         sat = lo[DW-1:0];
      end else begin
         sat = v[DW-1:0];
      end
   endfunction

   // Register words
   logic [31:0] test_word;
   logic [31:0] og_word;
   logic [31:0] next_test_word;
   logic [31:0] next_og_word;

   always_comb begin
      next_test_word = test_word;
      next_og_word = og_word;
      if (WR && ADDR == `TDAC_A_WORD) begin
         if (sel_is(WDATA, `TDAC_SEL_TEST)) begin
            next_test_word = WDATA;
         end
         if (sel_is(WDATA, `TDAC_SEL_OG)) begin
            next_og_word = WDATA;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         test_word <= `TDAC_TEST_RST;
         og_word <= `TDAC_OG_RST;
      end else begin
         test_word <= next_test_word;
         og_word <= next_og_word;
      end
   end

   // Fields
   logic [3:0] test_mode;
   logic [GW-1:0] gain;
   logic [OW-1:0] offset;
   logic [PW-1:0] stretch_code;

   assign test_mode = test_word[`TDAC_MODE_HI:`TDAC_MODE_LO];
   assign gain = og_word[`TDAC_GAIN_HI:`TDAC_GAIN_LO];
   assign offset = og_word[`TDAC_OFS_HI:`TDAC_OFS_LO];
   assign stretch_code = og_word[`TDAC_PE_HI:`TDAC_PE_LO];

   // Mode
   tdac_pkg::tdac_mode_e mode;
   tdac_pkg::tdac_mode_e next_mode;

   always_comb begin
      unique case (test_mode)
         `TDAC_MODE_RAW: next_mode = tdac_pkg::TDAC_RAW;
         `TDAC_MODE_OFS: next_mode = tdac_pkg::TDAC_OFS;
         default: next_mode = tdac_pkg::TDAC_OFF;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         mode <= tdac_pkg::TDAC_OFF;
      end else begin
         mode <= next_mode;
      end
   end

   logic enabled;
   assign enabled = (mode != tdac_pkg::TDAC_OFF);

   // Recovery clock synchroniser and edge detect
   logic rc_s1;
   logic rc_s2;
   logic rc_d;
   logic rc_step;
   logic next_rc_s1;
   logic next_rc_s2;
   logic next_rc_d;

   // Only the second stage feeds the edge history
   always_comb begin
      next_rc_s1 = RECOVERY_CLOCK;
      next_rc_s2 = rc_s1;
      next_rc_d = rc_s2;
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         rc_s1 <= 1'b0;
         rc_s2 <= 1'b0;
         rc_d <= 1'b0;
      end else begin
         rc_s1 <= next_rc_s1;
         rc_s2 <= next_rc_s2;
         rc_d <= next_rc_d;
      end
   end

   assign rc_step = rc_s2 && !rc_d;

   // Source and scaling
   logic signed [DW-1:0] src;
   logic signed [XW-1:0] diff;
   logic signed [SW-1:0] scaled;
   logic signed [DW-1:0] dac_in;
   logic signed [DW-1:0] next_dac_in;

   always_comb begin
      src = LIN_ACTIVE ? signed'(LIN_FILT) : signed'(CORR_FILT);
      diff = (XW'(src) <<< `TDAC_OFS_FRAC) - signed'(XW'({1'b0, offset}));
      scaled = (SW'(diff) <<< gain) >>> `TDAC_OFS_FRAC;
      next_dac_in = src;
      if (mode == tdac_pkg::TDAC_OFS) begin
         next_dac_in = sat(scaled);
      end
   end

   // Sampled so the arithmetic does not sit in front of the modulator
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         dac_in <= '0;
      end else begin
         dac_in <= next_dac_in;
      end
   end

   logic sdm_bit;

   tdac_sdm #(
      .W(DW)
   ) u_sdm (
      .clk(CORE_CLK),
      .rst_b(RST_B),
      .step(rc_step),
      .enable(enabled),
      .din(dac_in),
      .bit_out(sdm_bit)
   );

   logic wide_bit;

   tdac_stretch #(
      .CW(PW)
   ) u_stretch (
      .clk(CORE_CLK),
      .rst_b(RST_B),
      .step(rc_step),
      .code(stretch_code),
      .din(sdm_bit),
      .dout(wide_bit)
   );

   // Pin and readback
   logic pin;
   logic next_pin;
   logic [31:0] next_rdata;
   logic next_dac_enabled;

   always_comb begin
      next_pin = enabled ? wide_bit : 1'b0;
      next_dac_enabled = enabled;
      next_rdata = 32'h00000000;
      if (RD) begin
         unique case (ADDR)
            `TDAC_A_WORD: next_rdata = 32'h00000000;
            `TDAC_A_STATUS: next_rdata = {28'h0000000, LIN_ACTIVE, wide_bit, mode};
            `TDAC_A_TEST: next_rdata = test_word;
            `TDAC_A_OG: next_rdata = og_word;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         pin <= 1'b0;
         RDATA <= 32'h00000000;
         DAC_ENABLED <= 1'b0;
      end else begin
         pin <= next_pin;
         RDATA <= next_rdata;
         DAC_ENABLED <= next_dac_enabled;
      end
   end

   assign CLOCK_OUTPUT_PIN = pin;
endmodule

// >>> tdac_top_asserts.sv
// Checker for the test DAC block, bound to its top module.
// Sees only the top module's ports; one clock domain.
`timescale 1ns/1ns
module tdac_top_asserts (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_B,
   // Register port
   input wire logic [1:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   // Demodulator and outputs
   input wire logic LIN_ACTIVE,
   input wire logic CLOCK_OUTPUT_PIN,
   input wire logic DAC_ENABLED
);
   default clocking @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_B);
   // Test word write, then two quiet cycles
   sequence wr_c(c);
      WR && ADDR == 2'h0 && WDATA[3:0] == 4'hC && c ##1 !WR [*2];
   endsequence
   sequence wr_other;
      WR && (ADDR != 2'h0 || WDATA[3:0] != 4'hC) ##1 !WR [*2];
   endsequence
   raw_on_a: assert property (wr_c(WDATA[17:14] == 4'h7) |-> ##1 DAC_ENABLED)
      else $error("mode 7 did not enable");
   ofs_on_a: assert property (wr_c(WDATA[17:14] == 4'hA) |-> ##1 DAC_ENABLED)
      else $error("mode 10 did not enable");
   mode_off_a: assert property (wr_c(WDATA[17:14] != 4'h7 && WDATA[17:14] != 4'hA)
      |-> ##1 !DAC_ENABLED) else $error("other mode left enabled");
   keep_mode_a: assert property (wr_other |-> ##1 DAC_ENABLED == $past(DAC_ENABLED, 3))
      else $error("foreign write changed mode");
   rd_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("read data outside slot");
   stat_lin_a: assert property (RD && ADDR == 2'h1 |=>
      RDATA[31:4] == 28'h0 && RDATA[3] == $past(LIN_ACTIVE)) else $error("bad status");
   stat_mode_a: assert property (RD && ADDR == 2'h1 |=>
      (RDATA[1:0] != 2'h0) == DAC_ENABLED) else $error("status mode mismatch");
   pin_off_a: assert property (!DAC_ENABLED [*3] |-> !CLOCK_OUTPUT_PIN)
      else $error("pin active while off");
   pin_rise_a: assert property ($rose(CLOCK_OUTPUT_PIN) |-> DAC_ENABLED)
      else $error("pin rose while off");
endmodule
bind tdac_top tdac_top_asserts u_tdac_top_asserts (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LIN_ACTIVE(LIN_ACTIVE),
   .CLOCK_OUTPUT_PIN(CLOCK_OUTPUT_PIN), .DAC_ENABLED(DAC_ENABLED));

// >>> tdac_meter.sv
// Far-side model: recovery clock source and bitstream meter.
// Counters clear while not measuring; the clock stands low then.
`timescale 1ns/1ns
module tdac_meter #(
   parameter int HALF = 350,
   parameter int PHASE = 25
) (
   // Clock and control
   input wire logic clk,
   input wire logic run,
   // Bitstream side
   input wire logic pin,
   output logic rc,
   output int ones,
   output int total,
   output int edges,
   output int min_run
);
   logic last;
   logic seen;
   int run_len;
   // step clock, slower than half the core clock
   // Phase offset keeps its edges away from the core clock edges
   initial begin
      rc = 1'b0;
      #PHASE;
      forever #HALF rc = run ? ~rc : 1'b0;
   end
   // Density, edges and shortest run stand in for the external filter
   always @(posedge clk) begin
      last <= pin;
      // Unknown pin counts as a one, so it cannot pass a zero check
      ones <= run ? ones + int'(pin !== 1'b0) : 0;
      total <= run ? total + 1 : 0;
      edges <= run ? edges + int'(pin !== last) : 0;
      // First run is partial, so only runs between two edges count
      seen <= run && (seen || pin !== last);
      run_len <= (run && pin === last) ? run_len + 1 : 1;
      if (!run) begin
         min_run <= 100000;
      end else if (seen && pin !== last && run_len < min_run) begin
         min_run <= run_len;
      end
   end
endmodule

// >>> test_test_dac_offset_gain_control.sv
// Self-checking bench for the test DAC block.
// Drives the register port and filters; the meter makes the recovery clock.
`timescale 1ns/1ns
module test_test_dac_offset_gain_control;
   logic CORE_CLK = 1'b0, RST_B = 1'b0, WR = 1'b0, RD = 1'b0, LIN_ACTIVE = 1'b0;
   logic [1:0] ADDR = 2'h0;
   logic [31:0] WDATA = 32'h0, RDATA, r;
   logic [15:0] CORR_FILT = 16'h0, LIN_FILT = 16'h0;
   logic RECOVERY_CLOCK, CLOCK_OUTPUT_PIN, DAC_ENABLED;
   logic run = 1'b0, rd_seen = 1'b0;
   int ones, total, edges, min_run, mismatches = 0, checks_done = 0, seed = 32'hF8C0;
   logic [31:0] exp_q[$];
   always #50 CORE_CLK = ~CORE_CLK;
   tdac_top u_tdac_top (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .LIN_ACTIVE(LIN_ACTIVE), .CORR_FILT(CORR_FILT),
      .LIN_FILT(LIN_FILT), .RECOVERY_CLOCK(RECOVERY_CLOCK),
      .CLOCK_OUTPUT_PIN(CLOCK_OUTPUT_PIN), .DAC_ENABLED(DAC_ENABLED));
   tdac_meter u_tdac_meter (.clk(CORE_CLK), .run(run), .pin(CLOCK_OUTPUT_PIN),
      .rc(RECOVERY_CLOCK), .ones(ones), .total(total), .edges(edges), .min_run(min_run));
   task automatic cmp32(string what, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cmp_rng(string what, int lo, int hi, int g);
      checks_done++;
      if (g < lo || g > hi) begin
         mismatches++;
         $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, g);
      end
   endtask
   task automatic wr(logic [1:0] a, logic [31:0] d);
      @(posedge CORE_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CORE_CLK);
      WR <= 1'b0;
      repeat (3) @(posedge CORE_CLK);
   endtask
   task automatic rd(logic [1:0] a, logic [31:0] e);
      @(posedge CORE_CLK);
      ADDR <= a;
      RD <= 1'b1;
      exp_q.push_back(e);
      @(posedge CORE_CLK);
      RD <= 1'b0;
      repeat (3) @(posedge CORE_CLK);
   endtask
   // Read data stand only in the cycle after the strobe
   always @(posedge CORE_CLK) begin
      if (rd_seen) cmp32("read data", exp_q.pop_front(), RDATA);
      rd_seen <= RD;
   end
   // Density per mille, pin edges and shortest run in cycles, over 300 steps
   task automatic measure(int lo, int hi, int elo, int ehi, int rlo);
      run <= 1'b1;
      repeat (2100) @(posedge CORE_CLK);
      cmp_rng("ones per mille", lo, hi, ones * 1000 / total);
      cmp_rng("pin edges", elo, ehi, edges);
      cmp_rng("shortest run", rlo, 100000, min_run);
      run <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #3000000;
      mismatches++;
      stop_test();
   end
   initial begin
      repeat (12) @(posedge CORE_CLK);
      RST_B <= 1'b1;
      rd(2'h2, 32'h0000000C);
      rd(2'h3, 32'h0000000D);
      rd(2'h0, 32'h0);
      LIN_ACTIVE <= 1'b1;
      rd(2'h1, 32'h00000008);
      wr(2'h0, 32'h0001C00C);
      rd(2'h2, 32'h0001C00C);
      LIN_ACTIVE <= 1'b0;
      CORR_FILT <= 16'h6000;
      LIN_FILT <= 16'hA000;
      measure(835, 915, 1, 2100, 7);
      LIN_ACTIVE <= 1'b1;
      measure(85, 165, 1, 2100, 7);
      LIN_FILT <= 16'h0400;
      wr(2'h0, 32'h27FF000D);
      wr(2'h0, 32'h0002800C);
      measure(710, 790, 1, 2100, 7);
      wr(2'h0, 32'h0001C00C);
      measure(476, 556, 200, 2100, 7);
      wr(2'h0, 32'h27FFF00D);
      measure(0, 1000, 0, 21, 112);
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         wr(2'h1 + 2'(i % 3), r);
      end
      rd(2'h2, 32'h0001C00C);
      r = $random(seed);
      CORR_FILT <= r[31:16];
      LIN_ACTIVE <= 1'b0;
      wr(2'h0, {r[31:18], 2'b00, r[15:4], 4'hC});
      measure(0, 0, 0, 0, 7);
      stop_test();
   end
endmodule
